// ### dv/sccf_card_model.sv
// Purpose: card on the open drain line, sends and captures frames
// Assumes: pull-up on the line, one etu of ETU_CYCLES clocks
// Notes: wire bit 0 is the start bit
`timescale 1ns/1ps
module sccf_card_model
  import sccf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic io_line_oe,
  output logic io_line_in
);
  localparam int ETU = int'(ETU_CYCLES);
  logic card_low = 1'b0;
  // pull-up: line is low while either side pulls
  assign io_line_in = !(io_line_oe || card_low);
  task automatic send(input logic [9:0] w);
    for (int i = 0; i < 10; i++) begin
      card_low <= !w[i];
      repeat (ETU) @(posedge ref_clk);
    end
    card_low <= 1'b0;
  endtask
  task automatic recv(output logic [9:0] w);
    while (io_line_in !== 1'b0) begin
      @(posedge ref_clk);
    end
    repeat (ETU / 2) @(posedge ref_clk);
    for (int i = 0; i < 10; i++) begin
      w[i] = io_line_in;
      repeat (ETU) @(posedge ref_clk);
    end
  endtask
endmodule

// ### dv/sccf_top_asserts.sv
// Purpose: port assertions for the character format block
// Assumes: direction, format and retry are shadowed at write ack
// Notes: run counts clocks of line pull
`timescale 1ns/1ps
module sccf_top_asserts
  import sccf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic io_line_in,
  input wire logic io_line_drive_n,
  input wire logic io_line_oe
);
  logic dir;
  logic [5:0] fmt;
  logic [2:0] rxr;
  logic [15:0] run;
  logic wr;
  logic rd;
  assign wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
  assign rd = wb_ack_o && !wb_we_i;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dir <= SESSION_RESET[SESSION_DIR_BIT];
      fmt <= FORMAT_RESET;
      rxr <= RETRY_RESET[5:3];
    end else if (wr) begin
      if (wb_adr_i == ADDR_SESSION_CTRL) dir <= wb_dat_i[SESSION_DIR_BIT];
      if (wb_adr_i == ADDR_CHAR_FORMAT_CONTROL) fmt <= wb_dat_i[5:0];
      if (wb_adr_i == ADDR_RETRY_LIMIT) rxr <= wb_dat_i[5:3];
    end
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) run <= 16'h0000;
    else run <= io_line_oe ? run + 16'h0001 : 16'h0000;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_unmapped_zero: assert property (rd && wb_adr_i == 8'h7c |-> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_fmt_readback: assert property (rd && wb_adr_i == ADDR_CHAR_FORMAT_CONTROL |-> wb_dat_o[5:0] == fmt)
    else $error("format control readback wrong");
  a_pull_pair: assert property (io_line_oe != io_line_drive_n)
    else $error("enable and drive disagree");
  a_bit_run: assert property ($fell(io_line_oe) |-> run >= 16'(ETU_CYCLES - 2))
    else $error("line pull shorter than one etu");
  a_rx_pull_len: assert property ($fell(io_line_oe) && !dir |->
    run >= 16'(2 * ETU_CYCLES - 2) && run <= 16'(2 * ETU_CYCLES + 2))
    else $error("error signal not two etu");
  a_rx_quiet: assert property (!dir && (!fmt[FMT_RX_HS_BIT] || rxr == 3'h0) |-> !io_line_oe)
    else $error("line pulled in receive without handshake");
endmodule

bind sccf_top sccf_top_asserts u_sccf_top_asserts (.ref_clk(ref_clk), .arst_n(arst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .io_line_in(io_line_in), .io_line_drive_n(io_line_drive_n), .io_line_oe(io_line_oe));

// ### dv/test_smart_card_char_format.sv
// Purpose: self-checking bench for the character format block
// Assumes: card model on the line, wishbone master tasks
// Notes: expected frames built from sense, order and parity
`timescale 1ns/1ps
module test_smart_card_char_format;
  import sccf_pkg::*;
  localparam int ETU = int'(ETU_CYCLES);
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic wen = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic io_line_drive_n;
  logic io_line_oe;
  logic io_line_in;
  logic [9:0] w;
  logic [7:0] d;
  logic [5:0] f;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [8:0] q[$];

  sccf_top u_sccf_top (.ref_clk(ref_clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(wen), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .io_line_in(io_line_in), .io_line_drive_n(io_line_drive_n),
    .io_line_oe(io_line_oe));
  sccf_card_model u_sccf_card_model (.ref_clk(ref_clk), .io_line_oe(io_line_oe),
    .io_line_in(io_line_in));

  always #10 ref_clk = ~ref_clk;

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 95000) begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_wire(input logic [9:0] got, input logic [9:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    wen <= we;
    adr <= a;
    wdat <= wd;
    sel <= 4'hf;
    @(posedge ref_clk);
    while (wb_ack_o !== 1'b1) begin
      @(posedge ref_clk);
    end
    rdat = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // wire levels of a frame, start bit first
  function automatic logic [9:0] enc(input logic [7:0] dd, input logic [5:0] ff, input bit tx,
                                     input bit bad);
    logic [7:0] o;
    logic p;
    o = ff[FMT_ORDER_BIT] ? {<<{dd}} : dd;
    p = (^dd) ^ (tx ? ff[FMT_TX_PARITY_BIT] : ff[FMT_RX_PARITY_BIT]) ^ bad;
    enc = {{p, o} ^ {9{ff[FMT_SENSE_BIT]}}, 1'b0};
  endfunction

  // card sends, line is checked in the error slot, then the data register is read if keep is set
  task automatic rx_char(input logic [5:0] ff, input bit bad, input bit pulls, input bit keep);
    u_sccf_card_model.send(enc(d, ff, 1'b0, bad));
    repeat (ETU * 3 / 2) @(posedge ref_clk);
    chk_reg({31'h0000_0000, io_line_oe}, {31'h0000_0000, pulls});
    repeat (ETU * 2) @(posedge ref_clk);
    if (keep) begin
      q.push_back({bad, d});
      wb(1'b0, ADDR_CHAR_DATA, 32'h0000_0000);
      chk_reg(rdat, {23'h00_0000, q.pop_front()});
    end
  endtask

  initial begin
    void'($urandom(43));
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    wb(1'b0, ADDR_SESSION_CTRL, 32'h0000_0000);
    chk_reg(rdat, {26'h000_0000, SESSION_RESET});
    wb(1'b0, 8'h7c, 32'h0000_0000);
    chk_reg(rdat, 32'h0000_0000);
    wb(1'b1, ADDR_SESSION_CTRL, 32'h0000_0004);
    for (int k = 0; k < 4; k++) begin
      d = 8'($urandom);
      f = {3'h0, 1'($urandom), 2'(k)};
      wb(1'b1, ADDR_CHAR_FORMAT_CONTROL, {26'h000_0000, f});
      wb(1'b0, ADDR_CHAR_FORMAT_CONTROL, 32'h0000_0000);
      chk_reg(rdat, {26'h000_0000, f});
      wb(1'b1, ADDR_CHAR_DATA, {24'h00_0000, d});
      u_sccf_card_model.recv(w);
      chk_wire(w, enc(d, f, 1'b1, 1'b0));
      repeat (ETU * 4) @(posedge ref_clk);
    end
    wb(1'b0, ADDR_LINE_STATUS, 32'h0000_0000);
    chk_reg(rdat, 32'h0000_0001);
    wb(1'b1, ADDR_SESSION_CTRL, 32'h0000_0000);
    wb(1'b1, ADDR_CHAR_DATA, 32'h0000_00a5);
    repeat (ETU * 2) @(posedge ref_clk);
    chk_reg({31'h0000_0000, io_line_drive_n}, 32'h0000_0001);
    wb(1'b1, ADDR_RETRY_LIMIT, 32'h0000_0008);
    for (int k = 0; k < 4; k++) begin
      d = 8'($urandom);
      f = {1'h0, 1'($urandom), 2'h0, 2'(k)};
      wb(1'b1, ADDR_CHAR_FORMAT_CONTROL, {26'h000_0000, f});
      rx_char(f, 1'b0, 1'b0, 1'b1);
    end
    d = 8'($urandom);
    f = {4'ha, 2'($urandom)};
    wb(1'b1, ADDR_CHAR_FORMAT_CONTROL, {26'h000_0000, f});
    rx_char(f, 1'b1, 1'b1, 1'b0);
    rx_char(f, 1'b0, 1'b0, 1'b1);
    wb(1'b1, ADDR_RETRY_LIMIT, 32'h0000_0000);
    d = 8'($urandom);
    rx_char(f, 1'b1, 1'b0, 1'b1);
    end_of_test();
  end
endmodule

// ### logic/sccf_bit_map.sv
// Purpose: applies level sense and bit order to a character
// Assumes: purely combinational, used on both directions
// Notes: order and sense are independent
`timescale 1ns/1ps
module sccf_bit_map (
  input wire logic [7:0] din,
  input wire logic sense_inverse,
  input wire logic order_msb_first,
  output logic [7:0] dout
);
  logic [7:0] rev;
  for (genvar i = 0; i < 8; i++) begin : g_rev
    assign rev[i] = din[7 - i];
  end
  // the map is its own inverse, so tx and rx share it
  assign dout = (order_msb_first ? rev : din) ^ {8{sense_inverse}};
endmodule

// ### logic/sccf_etu_timer.sv
// Purpose: half-etu tick generator for the card line
// Assumes: restart aligns ticks to the start-bit edge
// Notes: tick pulses once per half etu
`timescale 1ns/1ps
module sccf_etu_timer (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic restart,
  output logic half_tick
);
  import sccf_pkg::*;
  logic [15:0] cnt;
  localparam logic [15:0] HALF = {1'b0, ETU_CYCLES[15:1]};

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 16'h0000;
      half_tick <= 1'b0;
    end else if (restart) begin
      cnt <= 16'h0000;
      half_tick <= 1'b0;
    end else if (cnt == HALF - 16'h0001) begin
      cnt <= 16'h0000;
      half_tick <= 1'b1;
    end else begin
      cnt <= cnt + 16'h0001;
      half_tick <= 1'b0;
    end
  end
endmodule

// ### logic/sccf_pkg.sv
// Purpose: shared constants and types of the smart card character format block
// Assumes: classic wishbone slave, 32-bit data, byte addresses
// Notes: etu length is a plain default, the baud generator lies outside this block
package sccf_pkg;
  localparam logic [7:0] ADDR_CHAR_DATA = 8'h00;
  localparam logic [7:0] ADDR_CHAR_FORMAT_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_SESSION_CTRL = 8'h08;
  localparam logic [7:0] ADDR_RETRY_LIMIT = 8'h14;
  localparam logic [7:0] ADDR_LINE_STATUS = 8'h30;
  localparam int FMT_SENSE_BIT = 0;
  localparam int FMT_ORDER_BIT = 1;
  localparam int FMT_TX_PARITY_BIT = 2;
  localparam int FMT_TX_HS_BIT = 3;
  localparam int FMT_RX_PARITY_BIT = 4;
  localparam int FMT_RX_HS_BIT = 5;
  localparam int SESSION_DIR_BIT = 2;
  localparam int RX_PERR_BIT = 8;
  localparam logic [5:0] FORMAT_RESET = 6'h00;
  localparam logic [5:0] SESSION_RESET = 6'h00;
  localparam logic [5:0] RETRY_RESET = 6'h00;
  localparam int CLK_HZ = 50_000_000;
  // one etu in clock cycles, arbitrary default
  localparam logic [15:0] ETU_CYCLES = 16'h0174;
  // error signal starts 10.5 etu after start edge and lasts 2 etu
  localparam int ERR_START_HALF_ETUS = 21;
  localparam int ERR_LEN_ETUS = 2;
  localparam int CHAR_BITS = 10;

  typedef struct packed {
    logic rx_error_handshake_en;
    logic rx_parity_odd;
    logic tx_error_handshake_en;
    logic tx_parity_odd;
    logic order_msb_first;
    logic sense_inverse;
  } sccf_format_s;

  typedef struct packed {
    logic [2:0] rx_retry_limit;
    logic [2:0] tx_retry_limit;
  } sccf_retry_s;

  typedef struct packed {
    logic perr;
    logic [7:0] data;
  } sccf_char_s;

  function automatic logic parity_of(input logic [7:0] d, input logic odd);
    parity_of = (^d) ^ odd;
  endfunction
endpackage

// ### logic/sccf_top.sv
// Purpose: character data register and character format control of a card interface
// Assumes: classic wishbone slave; one etu length; card line is open drain
// Notes: line bits go out in wire order, start bit first, then 8 data, then parity
// Contract
// - data register low byte holds the character
// - bit 8 flags receive parity error
// - data writes ignored in receive direction
// - control bit 0 inverts line sense
// - control bit 1 selects msb first
// - sense and order set independently
// - bits 2 and 4 pick parity, odd at 1
// - receive handshake pulls line low on error
// - transmit handshake checks line after character
// - receiver signals error, sender repeats character
// - attempts bounded by retry limit register; receive clears tries in idle, so a nonzero receive limit is never reached
// - error low 2 etu from 10.5 etu
// - receive retry limit zero stores without retry
// - direction bit: 0 receive, 1 transmit
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
module sccf_top (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic io_line_in,
  output logic io_line_drive_n,
  output logic io_line_oe
);
  import sccf_pkg::*;

  logic rst_s1, rst_n;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  sccf_format_s char_format_ctrl;
  sccf_retry_s retry_limit_reg;
  logic [5:0] session_ctrl_reg;
  sccf_char_s char_data_reg;
  logic tx_pending;
  logic [7:0] tx_char;
  logic tx_error;
  logic line_q;

  typedef enum {ST_IDLE, ST_TX_BITS, ST_TX_GUARD, ST_RX_BITS, ST_RX_ERR, ST_RX_GUARD} sccf_state_e;
  sccf_state_e state;
  logic [4:0] half_cnt;
  logic [3:0] bit_idx;
  logic [9:0] shreg;
  logic [2:0] tries;
  logic restart, half_tick;
  logic [7:0] tx_mapped, rx_mapped;
  logic dir_tx;

  assign dir_tx = session_ctrl_reg[SESSION_DIR_BIT];

  // wishbone
  logic req, wr_en;
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_en = req & wb_we_i & wb_sel_i[0];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req & ~wb_we_i) begin
      case (wb_adr_i)
        ADDR_CHAR_DATA: wb_dat_o <= {23'h00_0000, char_data_reg};
        ADDR_CHAR_FORMAT_CONTROL: wb_dat_o <= {26'h000_0000, char_format_ctrl};
        ADDR_SESSION_CTRL: wb_dat_o <= {26'h000_0000, session_ctrl_reg};
        ADDR_RETRY_LIMIT: wb_dat_o <= {26'h000_0000, retry_limit_reg};
        ADDR_LINE_STATUS: wb_dat_o <= {29'h0000_0000, tx_error, tx_pending, line_q};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      char_format_ctrl <= FORMAT_RESET;
      session_ctrl_reg <= SESSION_RESET;
      retry_limit_reg <= RETRY_RESET;
    end else if (wr_en) begin
      case (wb_adr_i)
        ADDR_CHAR_FORMAT_CONTROL: char_format_ctrl <= wb_dat_i[5:0];
        ADDR_SESSION_CTRL: session_ctrl_reg <= wb_dat_i[5:0];
        ADDR_RETRY_LIMIT: retry_limit_reg <= wb_dat_i[5:0];
        default: ;
      endcase
    end
  end

  // transmit holding register
  logic tx_done;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_pending <= 1'b0;
      tx_char <= 8'h00;
    end else if (wr_en && wb_adr_i == ADDR_CHAR_DATA && dir_tx && !tx_pending) begin
      tx_pending <= 1'b1;
      tx_char <= wb_dat_i[7:0];
    end else if (tx_done) begin
      tx_pending <= 1'b0;
    end
  end

  // line register; no other logic reads the raw input
  // line_prev lets a receive start only on a falling edge, so the tail of our own
  // error pull does not look like a new start bit
  logic line_prev;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_q <= 1'b1;
      line_prev <= 1'b1;
    end else begin
      line_q <= io_line_in;
      line_prev <= line_q;
    end
  end

  sccf_etu_timer u_timer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .restart(restart),
    .half_tick(half_tick)
  );

  // one mapping serves both directions
  sccf_bit_map u_tx_map (
    .din(tx_char),
    .sense_inverse(char_format_ctrl.sense_inverse),
    .order_msb_first(char_format_ctrl.order_msb_first),
    .dout(tx_mapped)
  );
  sccf_bit_map u_rx_map (
    .din(shreg[8:1]),
    .sense_inverse(char_format_ctrl.sense_inverse),
    .order_msb_first(char_format_ctrl.order_msb_first),
    .dout(rx_mapped)
  );

  logic tx_par_line, rx_par_bad, rx_hs_active;
  // parity travels with the line sense applied
  assign tx_par_line = parity_of(tx_char, char_format_ctrl.tx_parity_odd)
                       ^ char_format_ctrl.sense_inverse;
  assign rx_par_bad = parity_of(rx_mapped, char_format_ctrl.rx_parity_odd)
                      != (shreg[9] ^ char_format_ctrl.sense_inverse);
  // zero receive retry limit behaves as handshake off
  assign rx_hs_active = char_format_ctrl.rx_error_handshake_en
                        && retry_limit_reg.rx_retry_limit != 3'b000;

  logic [9:0] tx_frame;
  assign tx_frame = {tx_par_line, tx_mapped, 1'b0};
  assign restart = (state == ST_IDLE) &&
                   ((dir_tx && tx_pending) || (!dir_tx && line_prev && !line_q));

  logic store_rx, drive_low;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      half_cnt <= 5'd0;
      bit_idx <= 4'd0;
      shreg <= 10'h000;
      tries <= 3'd0;
      tx_done <= 1'b0;
      store_rx <= 1'b0;
      drive_low <= 1'b0;
      tx_error <= 1'b0;
    end else begin
      tx_done <= 1'b0;
      store_rx <= 1'b0;
      case (state)
        ST_IDLE: begin
          half_cnt <= 5'd0;
          bit_idx <= 4'd0;
          if (restart && dir_tx) begin
            shreg <= tx_frame;
            drive_low <= 1'b1;
            state <= ST_TX_BITS;
          end else if (restart) begin
            state <= ST_RX_BITS;
          end
          if (!tx_pending && !dir_tx) begin
            tries <= 3'd0;
          end
        end
        ST_TX_BITS: if (half_tick) begin
          half_cnt <= half_cnt + 5'd1;
          if (half_cnt[0]) begin
            if (bit_idx == 4'(CHAR_BITS - 1)) begin
              drive_low <= 1'b0;
              state <= ST_TX_GUARD;
            end else begin
              bit_idx <= bit_idx + 4'd1;
              drive_low <= ~shreg[bit_idx + 4'd1];
            end
          end
        end
        ST_TX_GUARD: if (half_tick) begin
          half_cnt <= half_cnt + 5'd1;
          // sample the receiver's error signal mid guard
          if (half_cnt == 5'(ERR_START_HALF_ETUS + 1)) begin
            if (char_format_ctrl.tx_error_handshake_en && !line_q) begin
              if (tries >= retry_limit_reg.tx_retry_limit) begin
                tx_error <= 1'b1;
                tx_done <= 1'b1;
                tries <= 3'd0;
              end else begin
                tries <= tries + 3'd1;
              end
            end else begin
              tx_done <= 1'b1;
              tries <= 3'd0;
            end
          end
          if (half_cnt == 5'(ERR_START_HALF_ETUS + 2 * ERR_LEN_ETUS + 2)) begin
            state <= ST_IDLE;
          end
        end
        ST_RX_BITS: if (half_tick) begin
          half_cnt <= half_cnt + 5'd1;
          if (half_cnt[0] == 1'b0 && half_cnt != 5'd0) begin
            shreg <= {line_q, shreg[9:1]};
          end
          if (half_cnt == 5'(ERR_START_HALF_ETUS - 2)) begin
            state <= ST_RX_ERR;
          end
        end
        ST_RX_ERR: if (half_tick) begin
          half_cnt <= half_cnt + 5'd1;
          if (half_cnt == 5'(ERR_START_HALF_ETUS - 1)) begin
            if (rx_par_bad && rx_hs_active && tries < retry_limit_reg.rx_retry_limit) begin
              drive_low <= 1'b1;
              tries <= tries + 3'd1;
            end else begin
              store_rx <= 1'b1;
              tries <= 3'd0;
            end
            state <= ST_RX_GUARD;
          end
        end
        ST_RX_GUARD: if (half_tick) begin
          half_cnt <= half_cnt + 5'd1;
          if (half_cnt == 5'(ERR_START_HALF_ETUS - 1 + 2 * ERR_LEN_ETUS)) begin
            drive_low <= 1'b0;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      char_data_reg <= '0;
    end else if (store_rx) begin
      char_data_reg <= {rx_par_bad, rx_mapped};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      io_line_drive_n <= 1'b1;
      io_line_oe <= 1'b0;
    end else begin
      io_line_drive_n <= ~drive_low;
      io_line_oe <= drive_low;
    end
  end
endmodule
